// [rtl/efs_line_ctrl.sv]
// E1 line-side sync, loss-of-signal and alarm control for one channel
`timescale 1ns/1ns
// Notes on behaviour
// - Reset brings channel up in E1 mode
// - Analog AMI/HDB3; digital AMI/HDB3/NRZ/CMI codes
// - Loss declared after programmed consecutive zeros count
// - Loss cleared after programmed ones in interval
// - Control registers read/write except command-type registers
// - Auto E-bit inserts received CRC4 status
// - Async state sends E-bits per polarity bit
// - Auto remote alarm follows frame alignment loss
// - Auto mode restarts search without multiframe in 8ms
// - Over 914 CRC4 errors per second forces resync
// - Interworking stays doubleframe, raises 400 ms event
// - Extended interworking sends alarm, keeps searching
module efs_line_ctrl #(
   parameter int MS_CYCLES = efs_pkg::CYC_PER_MS
) (
   input wire logic clock,
   input wire logic nrst,
   // Microprocessor port
   input wire logic cpu_sel,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   // Receive line events, one pulse per bit
   input wire logic rx_bit_valid,
   input wire logic rx_bit_one,
   // Framer status from the receive path
   input wire logic basic_frame_found,
   input wire logic mf_found,
   input wire logic crc4_error,
   input wire logic submf_crc_ok,
   input wire logic submf_strobe,
   input wire logic tx_mf_start,
   // Outputs to transmit and receive paths
   output logic line_standard_select,
   output logic [1:0] tx_code,
   output logic [1:0] rx_code,
   output logic cmi_enable,
   output logic digital_rail,
   output logic [7:0] global_clock_mode,
   output logic [1:0] tx_ebits,
   output logic send_rai,
   output logic loss_of_signal,
   output logic frame_align_lost,
   output logic restart_search,
   output logic iw_timeout_pulse,
   output logic receiver_soft_reset
);
   import efs_pkg::*;
   logic [7:0] ctrl0_ff, nxt_ctrl0;
   logic [7:0] ctrl1_ff, nxt_ctrl1;
   logic [7:0] code_ff, nxt_code;
   logic [7:0] los_det_ff, nxt_los_det;
   logic [7:0] los_rec_ff, nxt_los_rec;
   logic [7:0] clk_mode_ff, nxt_clk_mode;
   logic [7:0] cal_idx_ff, nxt_cal_idx;
   logic [7:0] cal_val_ff, nxt_cal_val;
   logic rx_reset_ff, nxt_rx_reset;
   logic [7:0] rdata_ff, nxt_rdata;
   // Address match helper
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit
   logic wr_en;
   assign wr_en = cpu_sel && cpu_wr;
   // Register writes; command register self-clears
   always_comb begin
      nxt_ctrl0 = ctrl0_ff;
      nxt_ctrl1 = ctrl1_ff;
      nxt_code = code_ff;
      nxt_los_det = los_det_ff;
      nxt_los_rec = los_rec_ff;
      nxt_clk_mode = clk_mode_ff;
      nxt_cal_idx = cal_idx_ff;
      nxt_cal_val = cal_val_ff;
      nxt_rx_reset = 1'b0;
      if (wr_en) begin
         if (hit(cpu_addr, OFS_CTRL0)) nxt_ctrl0 = cpu_wdata;
         if (hit(cpu_addr, OFS_CTRL1)) nxt_ctrl1 = cpu_wdata;
         if (hit(cpu_addr, OFS_CODE)) nxt_code = cpu_wdata;
         if (hit(cpu_addr, OFS_LOS_DET)) nxt_los_det = cpu_wdata;
         if (hit(cpu_addr, OFS_LOS_REC)) nxt_los_rec = cpu_wdata;
         if (hit(cpu_addr, OFS_CLK_MODE)) nxt_clk_mode = cpu_wdata;
         if (hit(cpu_addr, OFS_CAL_IDX)) nxt_cal_idx = cpu_wdata;
         if (hit(cpu_addr, OFS_CAL_VAL)) nxt_cal_val = cpu_wdata;
         if (hit(cpu_addr, OFS_CMD)) nxt_rx_reset = cpu_wdata[B_RX_RESET];
      end
   end
   // Register storage; reset selects E1 doubleframe
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl0_ff <= RST_ZERO;
         ctrl1_ff <= RST_ZERO;
         code_ff <= RST_ZERO;
         los_det_ff <= RST_ZERO;
         los_rec_ff <= RST_ZERO;
         clk_mode_ff <= RST_ZERO;
         cal_idx_ff <= RST_ZERO;
         cal_val_ff <= RST_ZERO;
         rx_reset_ff <= 1'b0;
      end else begin
         ctrl0_ff <= nxt_ctrl0;
         ctrl1_ff <= nxt_ctrl1;
         code_ff <= nxt_code;
         los_det_ff <= nxt_los_det;
         los_rec_ff <= nxt_los_rec;
         clk_mode_ff <= nxt_clk_mode;
         cal_idx_ff <= nxt_cal_idx;
         cal_val_ff <= nxt_cal_val;
         rx_reset_ff <= nxt_rx_reset;
      end
   end
   // Field decode
   efs_rfs_e rfs;
   assign rfs = efs_rfs_e'(ctrl0_ff[B_RFS_LO +: 2]);
   assign line_standard_select = ctrl0_ff[B_LINE_STD];
   assign tx_code = code_ff[1:0];
   assign rx_code = code_ff[3:2];
   assign cmi_enable = code_ff[4];
   assign digital_rail = code_ff[5];
   assign global_clock_mode = clk_mode_ff;
   assign receiver_soft_reset = rx_reset_ff;
   // Loss-of-signal counters
   logic [11:0] zero_cnt_ff, nxt_zero_cnt;
   logic [11:0] win_cnt_ff, nxt_win_cnt;
   logic [8:0] one_cnt_ff, nxt_one_cnt;
   logic los_ff, nxt_los;
   logic [12:0] det_limit; // Top count 0xFF needs 4096 zeros
   logic [8:0] rec_limit;
   assign det_limit = 13'((los_det_ff + 9'd1) * LOS_DET_SCALE);
   assign rec_limit = 9'(los_rec_ff + LOS_REC_ADD);
   always_comb begin
      nxt_zero_cnt = zero_cnt_ff;
      nxt_win_cnt = win_cnt_ff;
      nxt_one_cnt = one_cnt_ff;
      nxt_los = los_ff;
      if (rx_bit_valid) begin
         if (!los_ff) begin
            nxt_zero_cnt = rx_bit_one ? 12'h000 : zero_cnt_ff + 12'h001;
            if (!rx_bit_one && (zero_cnt_ff + 12'h001 >= det_limit)) begin
               nxt_los = 1'b1;
               nxt_zero_cnt = 12'h000;
               nxt_win_cnt = 12'h000;
               nxt_one_cnt = 9'h000;
            end
         end else begin
            nxt_one_cnt = one_cnt_ff + 9'(rx_bit_one);
            nxt_win_cnt = win_cnt_ff + 12'h001;
            if (rx_bit_one && (one_cnt_ff + 9'h001 >= rec_limit)) begin
               nxt_los = 1'b0;
               nxt_one_cnt = 9'h000;
               nxt_win_cnt = 12'h000;
            end else if (win_cnt_ff + 12'h001 >= det_limit) begin
               nxt_win_cnt = 12'h000; // New interval
               nxt_one_cnt = 9'h000;
            end
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         zero_cnt_ff <= 12'h000;
         win_cnt_ff <= 12'h000;
         one_cnt_ff <= 9'h000;
         los_ff <= 1'b0;
      end else begin
         zero_cnt_ff <= nxt_zero_cnt;
         win_cnt_ff <= nxt_win_cnt;
         one_cnt_ff <= nxt_one_cnt;
         los_ff <= nxt_los;
      end
   end
   assign loss_of_signal = los_ff;
   // Millisecond and second enables
   logic [31:0] ms_div_ff, nxt_ms_div;
   logic [9:0] sec_div_ff, nxt_sec_div;
   logic ms_tick, sec_tick;
   assign ms_tick = (ms_div_ff == 32'(MS_CYCLES - 1));
   assign sec_tick = ms_tick && (sec_div_ff == 10'(SECOND_MS - 1));
   always_comb begin
      nxt_ms_div = ms_tick ? 32'h0 : ms_div_ff + 32'h1;
      nxt_sec_div = sec_div_ff;
      if (ms_tick) nxt_sec_div = sec_tick ? 10'h000 : sec_div_ff + 10'h001;
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ms_div_ff <= 32'h0;
         sec_div_ff <= 10'h000;
      end else begin
         ms_div_ff <= nxt_ms_div;
         sec_div_ff <= nxt_sec_div;
      end
   end
   // Sync state machine with multiframe search timer
   efs_sync_e st_ff, nxt_st;
   logic [8:0] mf_ms_ff, nxt_mf_ms;
   logic [9:0] crc_cnt_ff, nxt_crc_cnt;
   logic iw_rai_ff, nxt_iw_rai;
   logic restart, iw_pulse;
   logic crc_over;
   assign crc_over = ctrl1_ff[B_AUTO_MF_RESYNC]
      && (crc_cnt_ff > 10'(CRC_ERR_LIMIT));
   always_comb begin
      nxt_st = st_ff;
      nxt_mf_ms = mf_ms_ff;
      nxt_iw_rai = iw_rai_ff;
      restart = 1'b0;
      iw_pulse = 1'b0;
      // CRC4 errors per second window; an error on the edge opens the next
      nxt_crc_cnt = sec_tick ? 10'h000 : crc_cnt_ff;
      if (crc4_error && (sec_tick || crc_cnt_ff != 10'h3FF))
         nxt_crc_cnt = nxt_crc_cnt + 10'h001;
      unique case (st_ff)
         EFS_ST_SEARCH: begin
            nxt_mf_ms = 9'h000;
            if (basic_frame_found) nxt_st = EFS_ST_BASIC;
         end
         EFS_ST_BASIC: begin
            if (ms_tick) nxt_mf_ms = mf_ms_ff + 9'h001;
            if (mf_found && rfs != EFS_RFS_DF) begin
               nxt_st = EFS_ST_MF;
               nxt_iw_rai = 1'b0;
            end else if (rfs == EFS_RFS_AUTO && ctrl1_ff[B_AUTO_RESYNC]
                  && mf_ms_ff >= 9'(MF_SEARCH_MS)) begin
               restart = 1'b1;
               nxt_st = EFS_ST_SEARCH;
            end else if (rfs == EFS_RFS_IW
                  && mf_ms_ff >= 9'(IW_TIMEOUT_MS)) begin
               iw_pulse = 1'b1;
               nxt_st = EFS_ST_IW_DF;
               nxt_iw_rai = ctrl1_ff[B_EXT_IW];
            end
         end
         EFS_ST_MF: begin
            if (crc_over) begin
               restart = 1'b1;
               nxt_st = EFS_ST_SEARCH;
               nxt_crc_cnt = 10'h000;
            end
         end
         EFS_ST_IW_DF: begin
            // Extended mode keeps looking for multiframe, no 8 ms resync
            if (mf_found && ctrl1_ff[B_EXT_IW]) begin
               nxt_st = EFS_ST_MF;
               nxt_iw_rai = 1'b0;
            end
         end
      endcase
      // Loss of basic framing drops back to search
      if (!basic_frame_found && st_ff != EFS_ST_SEARCH) begin
         nxt_st = EFS_ST_SEARCH;
         nxt_iw_rai = 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_ff <= EFS_ST_SEARCH;
         mf_ms_ff <= 9'h000;
         crc_cnt_ff <= 10'h000;
         iw_rai_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         mf_ms_ff <= nxt_mf_ms;
         crc_cnt_ff <= nxt_crc_cnt;
         iw_rai_ff <= nxt_iw_rai;
      end
   end

   // Registered pulses, alarm and E-bits
   logic rst_pulse_ff, iw_pulse_ff, rai_ff, nxt_rai;
   logic [1:0] ebits_ff, nxt_ebits;
   logic [1:0] submf_ff, nxt_submf;
   logic lfa;
   assign lfa = (st_ff == EFS_ST_SEARCH);
   always_comb begin
      nxt_rai = (ctrl1_ff[B_AUTO_RAI] && lfa) || iw_rai_ff;
      nxt_submf = submf_ff;
      if (submf_strobe) nxt_submf = {submf_ff[0], submf_crc_ok};
      nxt_ebits = ebits_ff;
      if (lfa)
         nxt_ebits = {2{ctrl1_ff[B_EBIT_POL]}};
      else if (tx_mf_start && ctrl1_ff[B_AUTO_EBIT])
         nxt_ebits = submf_ff;
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rst_pulse_ff <= 1'b0;
         iw_pulse_ff <= 1'b0;
         rai_ff <= 1'b0;
         ebits_ff <= 2'b11;
         submf_ff <= 2'b11;
      end else begin
         rst_pulse_ff <= restart;
         iw_pulse_ff <= iw_pulse;
         rai_ff <= nxt_rai;
         ebits_ff <= nxt_ebits;
         submf_ff <= nxt_submf;
      end
   end
   assign restart_search = rst_pulse_ff;
   assign iw_timeout_pulse = iw_pulse_ff;
   assign send_rai = rai_ff;
   assign tx_ebits = ebits_ff;
   assign frame_align_lost = lfa;

   // Read data; command register reads zero, unused addresses zero
   always_comb begin
      nxt_rdata = 8'h00;
      unique case (cpu_addr)
         OFS_CTRL0: nxt_rdata = ctrl0_ff;
         OFS_CTRL1: nxt_rdata = ctrl1_ff;
         OFS_CODE: nxt_rdata = code_ff;
         OFS_LOS_DET: nxt_rdata = los_det_ff;
         OFS_LOS_REC: nxt_rdata = los_rec_ff;
         OFS_STATUS: nxt_rdata = {3'h0, iw_rai_ff, rai_ff, los_ff, st_ff};
         OFS_CLK_MODE: nxt_rdata = clk_mode_ff;
         OFS_CAL_IDX: nxt_rdata = cal_idx_ff;
         OFS_CAL_VAL: nxt_rdata = cal_val_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end
   always_ff @(posedge clock) begin
      if (!nrst) rdata_ff <= 8'h00;
      else rdata_ff <= nxt_rdata;
   end
   assign cpu_rdata = rdata_ff;
endmodule : efs_line_ctrl

// [rtl/efs_pkg.sv]
// Package of constants for the E1 line-side control block
package efs_pkg;
   // Register offsets
   localparam logic [7:0] OFS_CTRL0 = 8'h00; // Line standard, framing mode
   localparam logic [7:0] OFS_CTRL1 = 8'h01; // Auto features
   localparam logic [7:0] OFS_CODE = 8'h02; // Line codes, CMI enable and digital rail
   localparam logic [7:0] OFS_LOS_DET = 8'h03; // Loss detect count
   localparam logic [7:0] OFS_LOS_REC = 8'h04; // Loss recover count
   localparam logic [7:0] OFS_CMD = 8'h05; // Command, write only
   localparam logic [7:0] OFS_STATUS = 8'h06; // Status, read only
   localparam logic [7:0] OFS_CLK_MODE = 8'h07; // Global clock mode
   localparam logic [7:0] OFS_CAL_IDX = 8'hBB;
   localparam logic [7:0] OFS_CAL_VAL = 8'hBC;
   // Field positions in control register 1
   localparam int B_AUTO_EBIT = 0;
   localparam int B_EBIT_POL = 1;
   localparam int B_AUTO_RAI = 2;
   localparam int B_AUTO_RESYNC = 3;
   localparam int B_AUTO_MF_RESYNC = 4;
   localparam int B_EXT_IW = 5;
   // Field positions in control register 0
   localparam int B_LINE_STD = 0;
   localparam int B_RFS_LO = 2;
   // Command bit for receiver soft reset
   localparam int B_RX_RESET = 0;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Loss count scaling: detect count n maps to 16*(n+1) zeros
   localparam int LOS_DET_SCALE = 16;
   localparam int LOS_REC_ADD = 1; // Recover count n means n+1 ones
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int MF_SEARCH_MS = 8;
   localparam int IW_TIMEOUT_MS = 400;
   localparam int SECOND_MS = 1000;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int CRC_ERR_LIMIT = 914;
   // Receive framing select codes
   typedef enum logic [1:0] {
      EFS_RFS_DF = 2'b00,
      EFS_RFS_MF = 2'b01,
      EFS_RFS_AUTO = 2'b10,
      EFS_RFS_IW = 2'b11
   } efs_rfs_e;
   // Framer sync states
   typedef enum logic [1:0] {
      EFS_ST_SEARCH = 2'b00,
      EFS_ST_BASIC = 2'b01,
      EFS_ST_MF = 2'b10,
      EFS_ST_IW_DF = 2'b11
   } efs_sync_e;
endpackage : efs_pkg

// [verif/efs_line_chk.sv]
// Assertion checker for the E1 line-side control block
`timescale 1ns/1ns
module efs_line_chk
   import efs_pkg::*;
#(
   parameter int MS_CYCLES = CYC_PER_MS
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cpu_sel,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   input wire logic rx_bit_valid,
   input wire logic rx_bit_one,
   input wire logic basic_frame_found,
   input wire logic [1:0] tx_ebits,
   input wire logic line_standard_select,
   input wire logic loss_of_signal,
   input wire logic frame_align_lost,
   input wire logic iw_timeout_pulse,
   input wire logic receiver_soft_reset
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // Port relations over time
   rst_vals_a: assert property ($rose(nrst) |->
      tx_ebits == 2'b11 && frame_align_lost && !line_standard_select)
      else $error("values after reset wrong");
   std_wr_a: assert property (cpu_sel && cpu_wr &&
      cpu_addr == OFS_CTRL0 |=> line_standard_select == $past(cpu_wdata[0]))
      else $error("line standard bit not written");
   cmd_pulse_a: assert property (cpu_sel && cpu_wr &&
      cpu_addr == OFS_CMD && cpu_wdata[0] |=> receiver_soft_reset ##1
      !receiver_soft_reset) else $error("soft reset pulse wrong");
   cmd_read_a: assert property (cpu_addr == OFS_CMD |=>
      cpu_rdata == 8'h00) else $error("command register readable");
   los_on_a: assert property ($rose(loss_of_signal) |->
      $past(rx_bit_valid) && !$past(rx_bit_one))
      else $error("loss raised without a zero");
   los_off_a: assert property ($fell(loss_of_signal) |->
      $past(rx_bit_valid) && $past(rx_bit_one))
      else $error("loss cleared without a one");
   los_hold_a: assert property (!rx_bit_valid |=>
      $stable(loss_of_signal)) else $error("loss moved without a bit");
   align_lost_a: assert property (!basic_frame_found |=>
      frame_align_lost) else $error("alignment kept without frame");
   iw_pulse_a: assert property (iw_timeout_pulse |=>
      !iw_timeout_pulse) else $error("timeout pulse too long");
endmodule : efs_line_chk

bind efs_line_ctrl efs_line_chk #(.MS_CYCLES(MS_CYCLES)) i_efs_line_chk (
   .clock, .nrst, .cpu_sel, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata,
   .rx_bit_valid, .rx_bit_one, .basic_frame_found, .tx_ebits,
   .line_standard_select, .loss_of_signal, .frame_align_lost,
   .iw_timeout_pulse, .receiver_soft_reset);

// [verif/efs_far.sv]
// Far-end E1 terminal model: line bits and framer status
`timescale 1ns/1ns
module efs_far (
   input wire logic clock,
   output logic rx_bit_valid,
   output logic rx_bit_one,
   output logic basic_frame_found,
   output logic mf_found,
   output logic crc4_error,
   output logic submf_crc_ok,
   output logic submf_strobe,
   output logic tx_mf_start
);
   // Idle line at time zero
   initial begin
      {rx_bit_valid, rx_bit_one, basic_frame_found, mf_found} = 4'h0;
      {crc4_error, submf_crc_ok, submf_strobe, tx_mf_start} = 4'h0;
   end
   // Send n bits of one value, one per cycle
   task automatic bits(input int n, input logic v);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         #1 rx_bit_valid = 1'b1;
         rx_bit_one = v;
      end
      @(posedge clock);
      #1 rx_bit_valid = 1'b0;
      rx_bit_one = ~v; // Data means nothing between bits
   endtask : bits
   // Alignment levels of the receive path
   task automatic lvl(input logic b, input logic m);
      @(posedge clock);
      #1 {basic_frame_found, mf_found} = {b, m};
   endtask : lvl
   // One-cycle events: submultiframe, multiframe start, CRC error
   task automatic ev(input logic s, input logic m, input logic c,
                     input logic ok);
      @(posedge clock);
      #1 {submf_strobe, tx_mf_start, crc4_error} = {s, m, c};
      submf_crc_ok = ok;
      @(posedge clock);
      #1 {submf_strobe, tx_mf_start, crc4_error} = 3'b000;
      submf_crc_ok = ~ok;
   endtask : ev
endmodule : efs_far

// [verif/efs_line_ctrl_tb.sv]
// Self-checking testbench for the E1 line-side control block
`timescale 1ns/1ns
module efs_line_ctrl_tb;
   import efs_pkg::*;
   localparam int MS = 10;
   logic clock, nrst, cpu_sel, cpu_wr;
   logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, global_clock_mode;
   logic rx_bit_valid, rx_bit_one, basic_frame_found, mf_found;
   logic crc4_error, submf_crc_ok, submf_strobe, tx_mf_start;
   logic line_standard_select, cmi_enable, digital_rail, send_rai;
   logic loss_of_signal, frame_align_lost, restart_search;
   logic iw_timeout_pulse, receiver_soft_reset;
   logic [1:0] tx_code, rx_code, tx_ebits;
   int fails = 0;
   int n_tests = 0;
   int n_rs = 0;
   efs_line_ctrl #(.MS_CYCLES(MS)) i_efs_line_ctrl (
      .clock, .nrst, .cpu_sel, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata,
      .rx_bit_valid, .rx_bit_one, .basic_frame_found, .mf_found,
      .crc4_error, .submf_crc_ok, .submf_strobe, .tx_mf_start,
      .line_standard_select, .tx_code, .rx_code, .cmi_enable,
      .digital_rail, .global_clock_mode, .tx_ebits, .send_rai,
      .loss_of_signal, .frame_align_lost, .restart_search,
      .iw_timeout_pulse, .receiver_soft_reset);
   efs_far i_efs_far (.clock, .rx_bit_valid, .rx_bit_one,
      .basic_frame_found, .mf_found, .crc4_error, .submf_crc_ok,
      .submf_strobe, .tx_mf_start);
   // Clock and restart pulse counter
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) if (restart_search === 1'b1) n_rs++;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 {cpu_sel, cpu_wr, cpu_addr, cpu_wdata} = {2'b11, a, d};
      @(posedge clock);
      #1 {cpu_sel, cpu_wr} = 2'b00;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      #1 {cpu_sel, cpu_wr, cpu_addr} = {2'b10, a};
      @(posedge clock);
      #1 cpu_sel = 1'b0;
      chk(cpu_rdata, e);
   endtask : rc
   // Cycles until a timeout or restart pulse, bounded
   task automatic wt(input logic iw, output int n);
      n = 0;
      while ((iw ? iw_timeout_pulse : restart_search) !== 1'b1 && n < 6000)
      begin
         @(posedge clock);
         #1 n++;
      end
   endtask : wt
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   task automatic t_crc;
      int k;
      wr(OFS_CTRL0, 8'h04);
      wr(OFS_CTRL1, 8'h10);
      i_efs_far.lvl(1'b1, 1'b1);
      repeat (3) @(posedge clock);
      k = n_rs;
      repeat (914) i_efs_far.ev(1'b0, 1'b0, 1'b1, 1'b0);
      chk(16'(n_rs), 16'(k));
      i_efs_far.ev(1'b0, 1'b0, 1'b1, 1'b0);
      repeat (3) @(posedge clock);
      #1 chk(16'(n_rs), 16'(k + 1));
      i_efs_far.lvl(1'b0, 1'b0);
   endtask : t_crc
   task automatic t_regs;
      logic [7:0] a[8] = '{OFS_CTRL0, OFS_CTRL1, OFS_CODE, OFS_LOS_DET,
         OFS_LOS_REC, OFS_CLK_MODE, OFS_CAL_IDX, OFS_CAL_VAL};
      logic [7:0] d[8] = '{8'h0C, 8'h2A, 8'h35, 8'h5A, 8'hA5, 8'hC3,
         8'h17, 8'h55};
      foreach (a[i]) wr(a[i], d[i]);
      foreach (a[i]) rc(a[i], d[i]);
      chk({tx_code, rx_code, cmi_enable, digital_rail}, 16'h17);
      chk(global_clock_mode, 8'hC3);
      wr(OFS_CMD, 8'h01);
      chk(receiver_soft_reset, 1'b1);
      rc(OFS_CMD, 8'h00);
      wr(OFS_CAL_IDX, 8'h17);
      wr(OFS_CAL_VAL, 8'h55);
      rc(OFS_CAL_VAL, 8'h55);
      wr(8'h50, 8'h00);
      rc(8'h50, 8'h00);
   endtask : t_regs
   task automatic t_los;
      wr(OFS_LOS_DET, 8'h0A);
      wr(OFS_LOS_REC, 8'h15);
      i_efs_far.bits(100, 1'b0);
      i_efs_far.bits(1, 1'b1);
      i_efs_far.bits(175, 1'b0);
      chk(loss_of_signal, 1'b0);
      i_efs_far.bits(1, 1'b0);
      chk(loss_of_signal, 1'b1);
      i_efs_far.bits(21, 1'b1);
      chk(loss_of_signal, 1'b1);
      i_efs_far.bits(1, 1'b1);
      chk(loss_of_signal, 1'b0);
   endtask : t_los
   task automatic t_ebr;
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL1, 8'h05);
      i_efs_far.ev(1'b0, 1'b1, 1'b0, 1'b0);
      chk(tx_ebits, 2'b00);
      chk(send_rai, 1'b1);
      wr(OFS_CTRL1, 8'h07);
      i_efs_far.ev(1'b0, 1'b1, 1'b0, 1'b0);
      chk(tx_ebits, 2'b11);
      i_efs_far.lvl(1'b1, 1'b0);
      repeat (3) @(posedge clock);
      #1 chk({send_rai, frame_align_lost}, 2'b00);
      repeat (2) i_efs_far.ev(1'b1, 1'b0, 1'b0, 1'b0);
      i_efs_far.ev(1'b0, 1'b1, 1'b0, 1'b0);
      chk(tx_ebits, 2'b00);
      i_efs_far.lvl(1'b0, 1'b0);
      repeat (3) @(posedge clock);
      #1 chk(send_rai, 1'b1);
   endtask : t_ebr
   task automatic t_sync;
      int n;
      int k;
      wr(OFS_CTRL0, 8'h08);
      wr(OFS_CTRL1, 8'h08);
      i_efs_far.lvl(1'b1, 1'b0);
      wt(1'b0, n);
      chk(n >= 7 * MS && n <= 9 * MS + 3, 1'b1);
      wr(OFS_CTRL1, 8'h20);
      wr(OFS_CTRL0, 8'h0C);
      i_efs_far.lvl(1'b0, 1'b0);
      i_efs_far.lvl(1'b1, 1'b0);
      k = n_rs;
      wt(1'b1, n);
      chk(n >= 399 * MS && n <= 401 * MS + 3, 1'b1);
      chk(frame_align_lost, 1'b0);
      repeat (2) @(posedge clock);
      #1 chk(send_rai, 1'b1);
      chk(16'(n_rs), 16'(k));
      // Extended mode still locks onto a late multiframe
      i_efs_far.lvl(1'b1, 1'b1);
      repeat (2) @(posedge clock);
      rc(OFS_STATUS, 8'h02);
   endtask : t_sync
   // Watchdog against a hung wait
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      end_sim();
   end
   // Reset, then the scenarios
   initial begin
      {nrst, cpu_sel, cpu_wr, cpu_addr, cpu_wdata} = '0;
      repeat (5) @(posedge clock);
      #1 nrst = 1'b1;
      chk(line_standard_select, 1'b0);
      rc(OFS_CTRL0, 8'h00);
      wr(OFS_CLK_MODE, 8'h00);
      chk(global_clock_mode, 8'h00);
      t_crc();
      t_regs();
      t_los();
      t_ebr();
      t_sync();
      end_sim();
   end
endmodule : efs_line_ctrl_tb
